// file: bmct_ctrl.sv
// Channel controller end: channel state words, bus monitor and page translation
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bmct_cfg.svh"
module bmct_ctrl (
  input wire logic clock, // 25 MHz clock
  input wire logic rst_n, // Asynchronous reset
  bmct_if.ctrl bus, // Expansion bus side
  input wire logic [7:0] sw_addr, // Register byte address
  input wire logic [31:0] sw_wdata, // Register write data
  input wire logic sw_we, // Register write strobe
  input wire logic sw_re, // Register read strobe
  output logic [31:0] sw_rdata, // Read data, cycle after strobe
  output logic mem_req, // System memory request, held to answer
  output logic mem_we, // System memory write
  output logic [31:0] mem_addr, // System memory real address
  output logic [31:0] mem_wdata, // System memory write data
  input wire logic [31:0] mem_rdata, // System memory read data
  input wire logic mem_ack, // System memory done pulse
  input wire logic mem_err // System memory error pulse
);
  localparam int CW = 32 - `BMCT_CSW_SHIFT;
  localparam int PB = `BMCT_PAGE_BITS;

  logic [CW-1:0] csw_q [0:`BMCT_NCHAN-1];
  logic ctrl_en_q;
  logic [31:0] te_base_q;
  logic [15:0] bmap_q;
  bmct_pkg::bmct_state_t state_q, state_d;
  logic [3:0] lvl_q;
  logic wr_q;
  logic [31:0] addr_q, wdata_q;
  logic te_vld_q;
  logic [31-PB:0] te_page_q;
  logic [31:0] te_q;
  logic wb_dirty_q;
  logic [31-PB:0] wb_page_q;
  logic [31:0] wb_addr_q, wb_data_q;
  logic inv_pend_q;
  logic [31-PB:0] inv_page_q;
  logic idle_q, done_q, chck_q;
  logic [31:0] rdata_q, sw_rdata_q;
  logic mem_req_q, mem_we_q;
  logic [31:0] mem_addr_q, mem_wdata_q;
  logic done_d, chck_d, mreq_d, mwe_d;
  logic [31:0] maddr_d, mwd_d, rdata_d;
  logic latch, decide, te_load, wb_set, wb_clr, inv_done, err_go;
  logic [3:0] err_code;

  // ==========================================================
  // Bus decode
  // Odd parity per address byte; I/O space only covers the low two bytes
  wire logic [3:0] par_bad;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_par
      assign par_bad[gi] = ~^{bus.addr[8*gi+7:8*gi], bus.addr_par[gi]};
    end
  endgenerate
  wire logic par_err = bus.mem_io ? |par_bad : |par_bad[1:0];
  // Level 15 has no word and reads as disabled
  wire logic [CW-1:0] bus_csw = (bus.arb_level < 4'(`BMCT_NCHAN)) ? csw_q[bus.arb_level] : '0;
  wire logic b_prev = bus_csw[`BMCT_CSW_PREV];
  wire logic b_en = (bus_csw[`BMCT_CSW_ST_HI:`BMCT_CSW_ST_LO] == `BMCT_ST_EN) && !bus_csw[`BMCT_CSW_SLAVE];
  // I/O space never reaches system memory
  wire logic b2b = !bus.mem_io || bmap_q[bus.addr[`BMCT_BLK_HI:`BMCT_BLK_LO]];

  // ==========================================================
  // Translation decode
  wire logic [31-PB:0] page = addr_q[31:PB];
  wire logic te_hit = te_vld_q && (te_page_q == page);
  wire logic [31:0] te_use = (state_q == bmct_pkg::ST_FETCH) ? mem_rdata : te_q;
  wire logic [31:0] real_addr = {te_use[31:PB], addr_q[PB-1:0]};
  wire logic ro_viol = wr_q && (te_use[`BMCT_MAP_HI:0] == `BMCT_MAP_RO);
  wire logic [31:0] te_addr = te_base_q + {10'h000, page, 2'h0};
  wire logic [3:0] err_lvl = (state_q == bmct_pkg::ST_IDLE) ? bus.arb_level : lvl_q;

  // ==========================================================
  // Register decode
  wire logic sw_csw = (sw_addr <= `BMCT_OFF_CSW_LAST) && (sw_addr[1:0] == 2'h0);
  wire logic [3:0] sw_ch = sw_addr[5:2];
  wire logic [CW-1:0] rd_csw = csw_q[sw_ch];
  wire logic [31:0] rd_mux =
    sw_csw ? {rd_csw, 26'h0000000} :
    (sw_addr == `BMCT_OFF_CTRL) ? {31'h00000000, ctrl_en_q} :
    (sw_addr == `BMCT_OFF_TEBASE) ? te_base_q :
    (sw_addr == `BMCT_OFF_STAT) ? {28'h0000000, inv_pend_q, wb_dirty_q, te_vld_q, idle_q} :
    (sw_addr == `BMCT_OFF_BMAP) ? {16'h0000, bmap_q} : 32'h00000000;

  // Per-channel state words; a hardware error wins over a same-cycle store
  generate
    for (gi = 0; gi < `BMCT_NCHAN; gi++) begin : g_csw
      wire logic hw_hit = err_go && (err_lvl == 4'(gi));
      wire logic sw_hit = sw_we && sw_csw && (sw_ch == 4'(gi));
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          csw_q[gi] <= '0;
        end else if (hw_hit) begin
          csw_q[gi][`BMCT_CSW_ST_HI:`BMCT_CSW_ST_LO] <= err_code;
        end else if (sw_hit) begin
          csw_q[gi] <= sw_wdata[31:`BMCT_CSW_SHIFT];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Transfer sequencing
  always_comb begin
    state_d = state_q;
    done_d = 1'b0;
    chck_d = 1'b0;
    err_go = 1'b0;
    err_code = `BMCT_ST_DIS;
    mreq_d = mem_req_q;
    mwe_d = mem_we_q;
    maddr_d = mem_addr_q;
    mwd_d = mem_wdata_q;
    rdata_d = rdata_q;
    latch = 1'b0;
    decide = 1'b0;
    te_load = 1'b0;
    wb_set = 1'b0;
    wb_clr = 1'b0;
    inv_done = 1'b0;
    unique case (state_q)
      bmct_pkg::ST_IDLE: begin
        if (bus.cycle_valid && ctrl_en_q) begin
          latch = 1'b1;
          if (par_err && b_prev) begin
            state_d = bmct_pkg::ST_IDLE; // Target unknown: no monitor, no log, no check
          end else if (par_err) begin
            err_go = 1'b1;
            err_code = `BMCT_ERR_APAR;
            chck_d = 1'b1;
          end else if (b2b) begin
            if (b_en && !b_prev) begin
              state_d = bmct_pkg::ST_MON;
            end
          end else if (!b_en) begin
            chck_d = 1'b1;
          end else if (wb_dirty_q) begin
            {mreq_d, mwe_d, maddr_d, mwd_d} = {2'h3, wb_addr_q, wb_data_q};
            state_d = bmct_pkg::ST_FLUSH;
          end else begin
            state_d = bmct_pkg::ST_LOOKUP;
          end
        end else if (inv_pend_q) begin
          if (wb_dirty_q && (wb_page_q == inv_page_q)) begin
            {mreq_d, mwe_d, maddr_d, mwd_d} = {2'h3, wb_addr_q, wb_data_q};
            state_d = bmct_pkg::ST_IFLUSH;
          end else begin
            inv_done = 1'b1;
          end
        end
      end
      bmct_pkg::ST_MON: begin
        state_d = bmct_pkg::ST_IDLE;
        if (!bus.card_sel_fb) begin
          err_go = 1'b1;
          err_code = `BMCT_ERR_CSF;
        end
      end
      bmct_pkg::ST_FLUSH: begin
        if (mem_ack || mem_err) begin
          mreq_d = 1'b0;
          wb_clr = 1'b1;
          state_d = mem_err ? bmct_pkg::ST_IDLE : bmct_pkg::ST_LOOKUP;
          err_go = mem_err;
          err_code = `BMCT_ERR_MEM;
          chck_d = mem_err;
        end
      end
      bmct_pkg::ST_LOOKUP: begin
        if (te_hit) begin
          decide = 1'b1;
        end else begin
          {mreq_d, mwe_d, maddr_d} = {2'h2, te_addr};
          state_d = bmct_pkg::ST_FETCH;
        end
      end
      bmct_pkg::ST_FETCH: begin
        if (mem_err) begin
          mreq_d = 1'b0;
          err_go = 1'b1;
          err_code = `BMCT_ERR_TE;
          chck_d = 1'b1;
          state_d = bmct_pkg::ST_IDLE;
        end else if (mem_ack) begin
          mreq_d = 1'b0;
          te_load = 1'b1;
          decide = 1'b1;
        end
      end
      bmct_pkg::ST_ACCESS: begin
        if (mem_ack || mem_err) begin
          mreq_d = 1'b0;
          done_d = mem_ack;
          rdata_d = mem_ack ? mem_rdata : rdata_q;
          err_go = mem_err;
          err_code = `BMCT_ERR_MEM;
          chck_d = mem_err;
          state_d = bmct_pkg::ST_IDLE;
        end
      end
      bmct_pkg::ST_IFLUSH: begin
        if (mem_ack || mem_err) begin
          mreq_d = 1'b0;
          wb_clr = 1'b1;
          inv_done = 1'b1; // Entry dropped once its flush answers, by ack or by error
          state_d = bmct_pkg::ST_IDLE;
        end
      end
      default: state_d = bmct_pkg::ST_IDLE;
    endcase
    // Mapping code decides the outcome once the entry is known
    if (decide) begin
      state_d = bmct_pkg::ST_IDLE;
      if (!te_use[`BMCT_MAP_HI]) begin
        err_go = 1'b1; // 00 and 01 both fault
        err_code = `BMCT_ERR_FAULT;
        chck_d = 1'b1;
      end else if (ro_viol) begin
        err_go = 1'b1;
        err_code = `BMCT_ERR_RO;
        chck_d = 1'b1;
      end else if (wr_q) begin
        wb_set = 1'b1; // Posted write, flushed before the next memory use
        done_d = 1'b1;
      end else begin
        {mreq_d, mwe_d, maddr_d} = {2'h2, real_addr};
        state_d = bmct_pkg::ST_ACCESS;
      end
    end
  end

  // ==========================================================
  // State, buffers and outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= bmct_pkg::ST_IDLE;
      {idle_q, done_q, chck_q, rdata_q, sw_rdata_q} <= '0;
      {mem_req_q, mem_we_q, mem_addr_q, mem_wdata_q} <= '0;
      {lvl_q, wr_q, addr_q, wdata_q} <= '0;
    end else begin
      state_q <= state_d;
      idle_q <= (state_d == bmct_pkg::ST_IDLE);
      {done_q, chck_q, rdata_q} <= {done_d, chck_d, rdata_d};
      {mem_req_q, mem_we_q, mem_addr_q, mem_wdata_q} <= {mreq_d, mwe_d, maddr_d, mwd_d};
      sw_rdata_q <= sw_re ? rd_mux : 32'h00000000;
      if (latch) begin
        {lvl_q, wr_q, addr_q, wdata_q} <= {bus.arb_level, bus.write, bus.addr, bus.wdata};
      end
    end
  end

  // Entry cache, write buffer and invalidate request; a new request wins over completion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {te_vld_q, te_page_q, te_q} <= '0;
      {wb_dirty_q, wb_page_q, wb_addr_q, wb_data_q} <= '0;
      {inv_pend_q, inv_page_q, ctrl_en_q, te_base_q, bmap_q} <= '0;
    end else begin
      if (te_load) begin
        {te_vld_q, te_page_q, te_q} <= {1'b1, page, mem_rdata};
      end else if (inv_done && (te_page_q == inv_page_q)) begin
        te_vld_q <= 1'b0;
      end
      if (wb_set) begin
        {wb_dirty_q, wb_page_q, wb_addr_q, wb_data_q} <= {1'b1, page, real_addr, wdata_q};
      end else if (wb_clr) begin
        wb_dirty_q <= 1'b0;
      end
      if (sw_we && (sw_addr == `BMCT_OFF_INVAL)) begin
        {inv_pend_q, inv_page_q} <= {1'b1, sw_wdata[31-PB:0]};
      end else if (inv_done) begin
        inv_pend_q <= 1'b0;
      end
      if (sw_we && (sw_addr == `BMCT_OFF_CTRL)) ctrl_en_q <= sw_wdata[0];
      if (sw_we && (sw_addr == `BMCT_OFF_TEBASE)) te_base_q <= sw_wdata;
      if (sw_we && (sw_addr == `BMCT_OFF_BMAP)) bmap_q <= sw_wdata[15:0];
    end
  end

  assign bus.idle = idle_q;
  assign bus.done = done_q;
  assign bus.chck = chck_q;
  assign bus.rdata = rdata_q;
  assign sw_rdata = sw_rdata_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
endmodule
`default_nettype wire

// file: bmct_cfg.svh
// Field positions, codes and register offsets of the bus-master channel block
`ifndef BMCT_CFG_SVH
`define BMCT_CFG_SVH
// ==========================================================
// Channel state words
`define BMCT_NCHAN 15
`define BMCT_CSW_SHIFT 26
`define BMCT_CSW_ST_HI 5
`define BMCT_CSW_ST_LO 2
`define BMCT_CSW_SLAVE 1
`define BMCT_CSW_PREV 0
`define BMCT_ST_DIS 4'h0
`define BMCT_ST_EN 4'h1
`define BMCT_ERR_APAR 4'h2
`define BMCT_ERR_CSF 4'h3
`define BMCT_ERR_FAULT 4'h4
`define BMCT_ERR_RO 4'h5
`define BMCT_ERR_TE 4'h6
`define BMCT_ERR_MEM 4'h7
// ==========================================================
// Translation entries and address split
`define BMCT_PAGE_BITS 12
`define BMCT_MAP_HI 1
`define BMCT_MAP_RO 2'h2
`define BMCT_BLK_HI 31
`define BMCT_BLK_LO 28
// ==========================================================
// Software register offsets
`define BMCT_OFF_CSW_LAST 8'h38
`define BMCT_OFF_CTRL 8'h40
`define BMCT_OFF_TEBASE 8'h44
`define BMCT_OFF_INVAL 8'h48
`define BMCT_OFF_STAT 8'h4c
`define BMCT_OFF_BMAP 8'h50
`endif

// file: bmct_pkg.sv
// Types shared by both ends of the bus-master channel block
package bmct_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_MON, ST_FLUSH, ST_LOOKUP, ST_FETCH, ST_ACCESS, ST_IFLUSH} bmct_state_t;
  typedef enum logic [0:0] {HS_IDLE, HS_WAIT} bmct_hstate_t;
endpackage

// file: bmct_if.sv
// Expansion bus seen between a bus master adapter and the channel controller
`timescale 1ns/1ps
`default_nettype none
interface bmct_if;
  logic cycle_valid;
  logic [3:0] arb_level;
  logic mem_io;
  logic write;
  logic [31:0] addr;
  logic [3:0] addr_par;
  logic [31:0] wdata;
  logic card_sel_fb;
  logic idle;
  logic done;
  logic chck;
  logic [31:0] rdata;
  modport ctrl (input cycle_valid, arb_level, mem_io, write, addr, addr_par, wdata, card_sel_fb,
                output idle, done, chck, rdata);
  modport master (output cycle_valid, arb_level, mem_io, write, addr, addr_par, wdata, card_sel_fb,
                  input idle, done, chck, rdata);
endinterface
`default_nettype wire

// file: bmct_master.sv
// Bus master adapter end: issues one transfer at a time and waits for its end
`timescale 1ns/1ps
`default_nettype none
module bmct_master (
  input wire logic clock, // 25 MHz clock
  input wire logic rst_n, // Asynchronous reset
  bmct_if.master bus, // Expansion bus side
  input wire logic req, // Start a transfer, one cycle
  input wire logic [3:0] req_level, // Arbitration level won
  input wire logic req_mem, // 1 memory space, 0 I/O space
  input wire logic req_write, // 1 write, 0 read
  input wire logic [31:0] req_addr, // Bus address
  input wire logic [31:0] req_wdata, // Write data
  input wire logic tgt_sel, // Bus target card-select feedback
  input wire logic tgt_ack, // Bus target finished, one cycle
  output logic busy, // Transfer in flight
  output logic done, // Controller completed, one cycle
  output logic chck, // Channel check seen, one cycle
  output logic [31:0] rdata // Read data with done
);
  bmct_pkg::bmct_hstate_t state_q;
  logic cyc_q, mem_q, wr_q, sel_q, done_q, chck_q;
  logic [3:0] lvl_q, par_q;
  logic [31:0] addr_q, wdata_q, rdata_q;

  // ==========================================================
  // Request acceptance and odd parity per address byte
  wire logic take = (state_q == bmct_pkg::HS_IDLE) && req && bus.idle;
  wire logic fin = (state_q == bmct_pkg::HS_WAIT) && (bus.done || bus.chck || tgt_ack);
  wire logic [3:0] par_d = {~^req_addr[31:24], ~^req_addr[23:16], ~^req_addr[15:8], ~^req_addr[7:0]};

  // Bus drive; a start needs both this end and the controller idle, and a request made otherwise is dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= bmct_pkg::HS_IDLE;
      {cyc_q, mem_q, wr_q, sel_q, done_q, chck_q} <= '0;
      {lvl_q, par_q, addr_q, wdata_q, rdata_q} <= '0;
    end else begin
      cyc_q <= take;
      sel_q <= tgt_sel;
      done_q <= fin && bus.done;
      chck_q <= fin && bus.chck;
      if (fin && bus.done) rdata_q <= bus.rdata;
      if (take) begin
        state_q <= bmct_pkg::HS_WAIT;
        {lvl_q, mem_q, wr_q, addr_q, wdata_q, par_q} <= {req_level, req_mem, req_write, req_addr, req_wdata, par_d};
      end else if (fin) begin
        state_q <= bmct_pkg::HS_IDLE;
      end
    end
  end

  assign bus.cycle_valid = cyc_q;
  assign bus.arb_level = lvl_q;
  assign bus.mem_io = mem_q;
  assign bus.write = wr_q;
  assign bus.addr = addr_q;
  assign bus.addr_par = par_q;
  assign bus.wdata = wdata_q;
  assign bus.card_sel_fb = sel_q;
  assign busy = (state_q == bmct_pkg::HS_WAIT);
  assign done = done_q;
  assign chck = chck_q;
  assign rdata = rdata_q;
endmodule
`default_nettype wire

// file: bmct_chk_properties.sv
// Concurrent checks on the expansion bus joining master and controller
`timescale 1ns/1ps
`default_nettype none
module bmct_chk (
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic cycle_valid, // Cycle presented
  input wire logic mem_io, // Space select
  input wire logic [31:0] addr, // Bus address
  input wire logic [3:0] addr_par, // Address parity
  input wire logic idle, // Controller free
  input wire logic done, // Done pulse
  input wire logic chck, // Channel check pulse
  input wire logic [31:0] rdata // Read data
);
  // ==========================================
  // Odd parity per byte
  wire logic [3:0] byte_ok;
  assign byte_ok = {^{addr[31:24], addr_par[3]}, ^{addr[23:16], addr_par[2]},
                    ^{addr[15:8], addr_par[1]}, ^{addr[7:0], addr_par[0]}};
  // Block 8 is the only one the bench maps to the bus
  wire logic bus_blk;
  assign bus_blk = addr[31:28] == 4'h8;
  // ==========================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_bus_take;
    cycle_valid && ((!mem_io && byte_ok[1:0] == 2'h3) || (mem_io && bus_blk && &byte_ok));
  endsequence
  sequence s_mem_take;
    cycle_valid && mem_io && !bus_blk && &byte_ok;
  endsequence
  sequence s_quiet;
    (!done && !chck) [*4];
  endsequence
  chk_take_idle: assert property (cycle_valid |-> idle) else $error("cycle while busy");
  chk_valid_pulse: assert property (cycle_valid |=> !cycle_valid) else $error("long cycle");
  chk_bus_silent: assert property (s_bus_take |=> s_quiet) else $error("answer on bus cycle");
  chk_mem_answer: assert property (s_mem_take |-> ##[1:80] (done || chck)) else $error("no answer");
  chk_no_early: assert property (s_mem_take |=> !done) else $error("done before lookup");
  chk_check_pulse: assert property (chck |=> !chck) else $error("long check");
  chk_done_excl: assert property (done |-> !chck ##1 !done) else $error("done and check");
  chk_rdata_hold: assert property (!$stable(rdata) |-> done) else $error("rdata moved");
endmodule
`default_nettype wire

// file: bus_master_channel_translation_tb.sv
// Bench: both ends joined, a memory model, and a raw driver on a second bus
`timescale 1ns/1ps
`default_nettype none
`include "bmct_cfg.svh"
module bus_master_channel_translation_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic sw_we = 1'b0;
  logic sw_re = 1'b0;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, sw_rdata2, mem_addr, mem_wdata, mem_rdata = 32'h0, m_rdata;
  logic mem_req, mem_we, mem_ack = 1'b0, mem_err = 1'b0, err_arm = 1'b0, busy, m_done, m_chck;
  logic req = 1'b0, req_mem = 1'b0, req_write = 1'b0, tgt_sel = 1'b1, tgt_ack = 1'b0;
  logic [3:0] req_level = 4'h0;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, last_ra = 32'h0, last_wa = 32'h0, last_wd = 32'h0;
  logic [31:0] te [0:15];
  int fails = 0;
  int cmp_count = 0;
  int mem_n = 0;
  bmct_if bif();
  bmct_if bif2();
  always #20 clock = ~clock;
  // ==========================================
  // Design ends and checker
  bmct_ctrl i_bmct_ctrl (.clock(clock), .rst_n(rst_n), .bus(bif.ctrl), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err));
  // Second controller sees only bad-parity traffic, so it never reaches memory
  bmct_ctrl i_bmct_ctrl_2 (.clock(clock), .rst_n(rst_n), .bus(bif2.ctrl), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata2), .mem_req(), .mem_we(), .mem_addr(), .mem_wdata(),
    .mem_rdata(32'h0), .mem_ack(1'b0), .mem_err(1'b0));
  bmct_master i_bmct_master (.clock(clock), .rst_n(rst_n), .bus(bif.master), .req(req), .req_level(req_level),
    .req_mem(req_mem), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .tgt_sel(tgt_sel),
    .tgt_ack(tgt_ack), .busy(busy), .done(m_done), .chck(m_chck), .rdata(m_rdata));
  bmct_chk i_bmct_chk (.clock(clock), .rst_n(rst_n), .cycle_valid(bif.cycle_valid), .mem_io(bif.mem_io),
    .addr(bif.addr), .addr_par(bif.addr_par), .idle(bif.idle), .done(bif.done), .chck(bif.chck), .rdata(bif.rdata));
  // Memory answers a cycle after the request; the entry table is real page 1
  always @(posedge clock) begin
    mem_ack <= mem_req && !mem_ack && !mem_err && !err_arm;
    mem_err <= mem_req && !mem_ack && !mem_err && err_arm;
    mem_rdata <= (mem_addr[31:12] == 20'h00001) ? te[mem_addr[5:2]] : ~mem_addr;
    if (mem_req && !mem_ack && !mem_err) begin
      mem_n <= mem_n + 1;
      if (mem_we) begin
        last_wa <= mem_addr;
        last_wd <= mem_wdata;
      end else begin
        last_ra <= mem_addr;
      end
    end
  end
  // ==========================================
  // Shared tasks
  function automatic logic [3:0] opar(input logic [31:0] a);
    return {~^a[31:24], ~^a[23:16], ~^a[15:8], ~^a[7:0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_we <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clock);
    sw_we <= 1'b0;
  endtask
  task automatic sw_rd(input logic [7:0] a, output logic [31:0] d, output logic [31:0] d2);
    @(posedge clock);
    sw_re <= 1'b1;
    sw_addr <= a;
    @(posedge clock);
    sw_re <= 1'b0;
    #1;
    d = sw_rdata;
    d2 = sw_rdata2;
  endtask
  task automatic chk_st(input string what, input int ch, input logic [3:0] exp, input bit second);
    logic [31:0] d, d2;
    sw_rd(8'(ch * 4), d, d2);
    check(what, second ? d2[31:28] : d[31:28], exp);
  endtask
  // One transfer; res 1 done, 2 check, 0 ended by the bus target
  task automatic xfer(input logic [3:0] lv, input logic m, w, b2b, input logic [31:0] a, d, output logic [1:0] res);
    int n;
    #1;
    for (n = 0; n < 50 && (busy !== 1'b0 || bif.idle !== 1'b1); n++)
      @(posedge clock);
    @(posedge clock);
    req <= 1'b1;
    req_level <= lv;
    req_mem <= m;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clock);
    req <= 1'b0;
    res = 2'h0;
    for (n = 0; n < 60 && res == 2'h0 && !(n > 8 && busy === 1'b0); n++) begin
      @(posedge clock);
      tgt_ack <= b2b && n == 5;
      #1;
      if (m_done === 1'b1) res = 2'h1;
      if (m_chck === 1'b1) res = 2'h2;
    end
  endtask
  // Raw cycle on the second bus with chosen parity bits flipped
  task automatic raw(input logic [3:0] lv, input logic m, input logic [31:0] a, input logic [3:0] flip, output logic s);
    @(posedge clock);
    bif2.cycle_valid <= 1'b1;
    bif2.arb_level <= lv;
    bif2.mem_io <= m;
    bif2.addr <= a;
    bif2.addr_par <= opar(a) ^ flip;
    @(posedge clock);
    bif2.cycle_valid <= 1'b0;
    s = 1'b0;
    repeat (4) begin
      #1;
      s = s | (bif2.chck === 1'b1);
      @(posedge clock);
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] d, d2;
    sw_rd(8'h00, d, d2);
    check("word 0 reset", d, 32'h0);
    sw_rd(8'h3c, d, d2);
    check("word 15", d, 32'h0);
    sw_wr(8'h0c, 32'hffffffff);
    sw_rd(8'h0c, d, d2);
    check("word 3 fields", d, 32'hfc000000);
  endtask
  task automatic t_translate;
    logic [1:0] r;
    logic [31:0] d, d2;
    xfer(4'h1, 1'b1, 1'b0, 1'b0, 32'h00001234, 32'h0, r);
    check("read result", r, 32'h1);
    check("real address", last_ra, 32'h00abc234);
    check("read data", m_rdata, 32'hff543dcb);
    xfer(4'h1, 1'b1, 1'b1, 1'b0, 32'h00001ff0, 32'hc0ffee01, r);
    check("posted write", r, 32'h1);
    sw_rd(8'h4c, d, d2);
    check("buffer dirty", d[2], 32'h1);
    sw_wr(8'h48, 32'h00000001);
    d = 32'hffffffff;
    for (int i = 0; i < 20 && d[3] !== 1'b0; i++)
      sw_rd(8'h4c, d, d2);
    check("flush address", last_wa, 32'h00abcff0);
    check("flush data", last_wd, 32'hc0ffee01);
    check("entry dropped", d[2:1], 32'h0);
    xfer(4'h1, 1'b1, 1'b0, 1'b0, 32'h00002008, 32'h0, r);
    check("second page", last_ra, 32'h00def008);
    xfer(4'h1, 1'b1, 1'b1, 1'b0, 32'h00002008, 32'h1, r);
    check("read-only write", r, 32'h2);
    chk_st("read-only status", 1, `BMCT_ERR_RO, 1'b0);
    sw_wr(8'h04, 32'h10000000);
  endtask
  // Faults on the channel that prevents disable, which must not help here
  task automatic t_faults;
    logic [1:0] r;
    for (int p = 3; p < 6; p++) begin
      err_arm <= (p == 5);
      xfer(4'h2, 1'b1, 1'b0, 1'b0, {16'h0, 4'(p), 12'h010}, 32'h0, r);
      err_arm <= 1'b0;
      check("fault answer", r, 32'h2);
      chk_st("fault status", 2, p == 5 ? `BMCT_ERR_TE : `BMCT_ERR_FAULT, 1'b0);
      sw_wr(8'h08, 32'h14000000);
    end
    // Cache page 2, then fail the data access on a hit
    xfer(4'h2, 1'b1, 1'b0, 1'b0, 32'h00002008, 32'h0, r);
    err_arm <= 1'b1;
    xfer(4'h2, 1'b1, 1'b0, 1'b0, 32'h00002008, 32'h0, r);
    err_arm <= 1'b0;
    check("memory error answer", r, 32'h2);
    chk_st("memory error status", 2, `BMCT_ERR_MEM, 1'b0);
    sw_wr(8'h08, 32'h14000000);
  endtask
  task automatic t_monitor;
    logic [1:0] r;
    int n0;
    n0 = mem_n;
    xfer(4'h1, 1'b0, 1'b0, 1'b1, 32'h00001234, 32'h0, r);
    xfer(4'h1, 1'b1, 1'b1, 1'b1, 32'h80000010, 32'h5, r);
    check("bus answer", r, 32'h0);
    check("memory untouched", mem_n - n0, 32'h0);
    chk_st("monitor status", 1, `BMCT_ST_EN, 1'b0);
    tgt_sel <= 1'b0;
    xfer(4'h2, 1'b0, 1'b0, 1'b1, 32'h00000300, 32'h0, r);
    chk_st("kept enabled", 2, `BMCT_ST_EN, 1'b0);
    xfer(4'h1, 1'b0, 1'b0, 1'b1, 32'h00000300, 32'h0, r);
    tgt_sel <= 1'b1;
    chk_st("feedback error", 1, `BMCT_ERR_CSF, 1'b0);
    xfer(4'h4, 1'b1, 1'b0, 1'b0, 32'h00001000, 32'h0, r);
    check("disabled channel", r, 32'h2);
    xfer(4'hf, 1'b1, 1'b0, 1'b0, 32'h00001000, 32'h0, r);
    check("no word", r, 32'h2);
  endtask
  // Mem bad, I/O upper bad, I/O low bad, mem bad with prevent
  task automatic t_parity;
    logic s;
    logic [3:0] flips [0:3];
    flips = '{4'h8, 4'hc, 4'h1, 4'h2};
    for (int k = 0; k < 4; k++) begin
      raw(k == 3 ? 4'h2 : 4'h1, k == 0 || k == 3, 32'hc3a50300, flips[k], s);
      check("parity check", s, {31'h0, ~k[0]});
      chk_st("parity status", k == 3 ? 2 : 1, k[0] ? `BMCT_ST_EN : `BMCT_ERR_APAR, 1'b1);
      sw_wr(8'h04, 32'h10000000);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence; key bits of every entry stay zero
  initial begin
    bif2.cycle_valid = 1'b0;
    bif2.arb_level = 4'h0;
    bif2.mem_io = 1'b0;
    bif2.write = 1'b0;
    bif2.addr = 32'h0;
    bif2.addr_par = 4'hf;
    bif2.wdata = 32'h0;
    bif2.card_sel_fb = 1'b1;
    for (int i = 0; i < 16; i++)
      te[i] = 32'h0;
    te[1] = 32'h00abc003;
    te[2] = 32'h00def002;
    te[3] = 32'h00000001;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    sw_wr(8'h40, 32'h1);
    sw_wr(8'h44, 32'h00001000);
    sw_wr(8'h50, 32'h00000100); // Only block 8 is bus memory, far above 512 KB
    sw_wr(8'h04, 32'h10000000);
    sw_wr(8'h08, 32'h14000000);
    t_translate;
    t_faults;
    t_monitor;
    t_parity;
    end_of_test;
  end
  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
